// >>> hw/usb_ep_access.sv
// endpoint register file, fifo access and interrupt summary behind apb
`timescale 1ns/1ps
module usb_ep_access #(
    parameter int DEPTH = usb_ep_pkg::FIFO_DEPTH,
    parameter int PTR_W = usb_ep_pkg::PTR_W
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usb_ep_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_bus_reset,
    input wire logic [2:0] usb_ep,
    input wire logic usb_nak_in,
    input wire logic usb_nak_out,
    input wire logic usb_stall_sent,
    input wire logic usb_iso_crc_err,
    input wire logic usb_setup_done,
    input wire logic usb_out_done,
    input wire logic usb_in_done,
    input wire logic usb_overflow,
    input wire logic usb_underflow,
    input wire logic usb_rx_valid,
    input wire logic [7:0] usb_rx_byte,
    input wire logic usb_tx_req,
    output logic [7:0] usb_tx_byte,
    output logic usb_tx_valid,
    output logic [6:0] in_bank_ready,
    output logic [6:0] out_bank_free,
    output logic [6:0] stall_request,
    output logic endpoint_irq,
    output logic irq
);
    localparam int N = usb_ep_pkg::EP_COUNT;
    localparam int CW = usb_ep_pkg::COUNT_W;
    localparam int AW = usb_ep_pkg::SEL_W + PTR_W;

    function automatic logic [N-1:0] ep_onehot(input logic [2:0] ep, input logic v);
        logic [N-1:0] r;
        r = '0;
        if (v && ep != usb_ep_pkg::FORBIDDEN_SEL)
        begin
            r[ep] = 1'b1;
        end
        return r;
    endfunction

    fifo_mem_if #(.AW(AW)) mem_bus ();

    logic [2:0] endpoint_select;
    logic [usb_ep_pkg::IRQ_W-1:0] irq_status;
    logic [usb_ep_pkg::IRQ_W-1:0] irq_mask;
    logic rd_wait;
    logic [7:0] ep_flags [N];
    logic [7:0] ep_enables [N];
    logic [1:0] ep_iso [N];
    logic [2:0] ep_cfg [N];
    logic [CW-1:0] ep_count [N];
    logic [PTR_W-1:0] ep_wr [N];
    logic [PTR_W-1:0] ep_rd [N];
    logic [N-1:0] ep_busy;
    logic [N-1:0] ep_full;
    logic [N-1:0] ep_empty;
    logic [N-1:0] endpoint_irq_summary;
    logic [N-1:0] ep_dir_in;
    logic [N-1:0] push_vec;
    logic [N-1:0] pop_vec;
    logic [31:0] next_rdata;

    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_select = paddr == usb_ep_pkg::OFS_SELECT;
    wire hit_flags = paddr == usb_ep_pkg::OFS_FLAGS;
    wire hit_enables = paddr == usb_ep_pkg::OFS_ENABLES;
    wire hit_data = paddr == usb_ep_pkg::OFS_DATA;
    wire hit_cnt_hi = paddr == usb_ep_pkg::OFS_COUNT_HIGH;
    wire hit_cnt_lo = paddr == usb_ep_pkg::OFS_COUNT_LOW;
    wire hit_summary = paddr == usb_ep_pkg::OFS_SUMMARY;
    wire hit_iso = paddr == usb_ep_pkg::OFS_ISO_FLAGS;
    wire hit_cfg = paddr == usb_ep_pkg::OFS_CONFIG;
    wire hit_status = paddr == usb_ep_pkg::OFS_IRQ_STATUS;
    wire hit_mask = paddr == usb_ep_pkg::OFS_IRQ_MASK;
    wire mapped = hit_select | hit_flags | hit_enables | hit_data | hit_cnt_hi
        | hit_cnt_lo | hit_summary | hit_iso | hit_cfg | hit_status | hit_mask;
    wire data_read = access_ph & ~pwrite & hit_data;
    wire done = access_ph & pready;
    wire wr_done = done & pwrite & mapped;
    wire [N-1:0] cpu_sel = ep_onehot(endpoint_select, 1'b1);
    wire [N-1:0] usb_sel = ep_onehot(usb_ep, 1'b1);
    wire [7:0] wbyte = pwdata[7:0];

    wire sel_dir_in = ep_dir_in[endpoint_select];
    wire sel_busy = ep_busy[endpoint_select];
    wire cpu_push = wr_done & hit_data & sel_dir_in & ~sel_busy & ~ep_full[endpoint_select];
    wire cpu_pop = done & ~pwrite & hit_data & ~sel_dir_in & ~ep_empty[endpoint_select];
    wire cpu_bad = done & hit_data & ~(pwrite ? cpu_push : cpu_pop);
    wire bad_select = wr_done & hit_select & (wbyte[2:0] == usb_ep_pkg::FORBIDDEN_SEL);
    wire usb_dir_in = (usb_ep != usb_ep_pkg::FORBIDDEN_SEL) & ep_dir_in[usb_ep];
    wire usb_busy = (usb_ep != usb_ep_pkg::FORBIDDEN_SEL) & ep_busy[usb_ep];
    wire usb_push = usb_rx_valid & (usb_ep != usb_ep_pkg::FORBIDDEN_SEL) & ~usb_dir_in
        & ~usb_busy & ~ep_full[usb_ep];
    wire usb_pop = usb_tx_req & usb_dir_in & usb_busy & ~ep_empty[usb_ep];

    assign pready = ~data_read | rd_wait;
    assign pslverr = access_ph & ~mapped;
    assign endpoint_irq = |endpoint_irq_summary;
    assign irq = |(irq_status & irq_mask);
    // memory output register holds the byte popped one cycle earlier
    assign usb_tx_byte = usb_tx_valid ? mem_bus.b_rdata : 8'h00;
    assign push_vec = (cpu_sel & {N{cpu_push}}) | (usb_sel & {N{usb_push}});
    assign pop_vec = (cpu_sel & {N{cpu_pop}}) | (usb_sel & {N{usb_pop}});

    assign mem_bus.a_we = cpu_push;
    assign mem_bus.a_addr = {endpoint_select,
        sel_dir_in ? ep_wr[endpoint_select] : ep_rd[endpoint_select]};
    assign mem_bus.a_wdata = wbyte;
    assign mem_bus.b_we = usb_push;
    assign mem_bus.b_addr = {usb_ep, usb_dir_in ? ep_rd[usb_ep] : ep_wr[usb_ep]};
    assign mem_bus.b_wdata = usb_rx_byte;

    ep_fifo_mem #(.AW(AW)) u_mem (
        .clk(pclk),
        .port(mem_bus.mem)
    );

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ep
            wire reg_we = wr_done & cpu_sel[g];
            ep_state_unit #(.DEPTH(DEPTH), .PTR_W(PTR_W), .COUNT_W(CW)) u_ep (
                .clk(pclk),
                .rstn(presetn),
                .clr(usb_bus_reset),
                .flags_we(reg_we & hit_flags),
                .enables_we(reg_we & hit_enables),
                .iso_we(reg_we & hit_iso),
                .cfg_we(reg_we & hit_cfg),
                .wdata(wbyte),
                .ev_nak_in(usb_sel[g] & usb_nak_in),
                .ev_nak_out(usb_sel[g] & usb_nak_out),
                .ev_stall(usb_sel[g] & usb_stall_sent),
                .ev_crc(usb_sel[g] & usb_iso_crc_err),
                .ev_setup(usb_sel[g] & usb_setup_done),
                .ev_out_done(usb_sel[g] & usb_out_done),
                .ev_in_done(usb_sel[g] & usb_in_done),
                .ev_overflow(usb_sel[g] & usb_overflow),
                .ev_underflow(usb_sel[g] & usb_underflow),
                .push(push_vec[g]),
                .pop(pop_vec[g]),
                .flags_rd(ep_flags[g]),
                .enables(ep_enables[g]),
                .iso_flags(ep_iso[g]),
                .cfg(ep_cfg[g]),
                .count(ep_count[g]),
                .wr_ptr(ep_wr[g]),
                .rd_ptr(ep_rd[g]),
                .bank_busy(ep_busy[g]),
                .full(ep_full[g]),
                .empty(ep_empty[g]),
                .irq_bit(endpoint_irq_summary[g])
            );
            assign ep_dir_in[g] = ep_cfg[g][usb_ep_pkg::CFG_DIR_IN];
            assign in_bank_ready[g] = ep_dir_in[g] & ep_busy[g];
            assign out_bank_free[g] = ~ep_dir_in[g] & ~ep_busy[g];
            assign stall_request[g] = ep_cfg[g][usb_ep_pkg::CFG_STALL_REQ];
        end
    endgenerate

    // read mux for the selected endpoint
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit_select)
        begin
            next_rdata[2:0] = endpoint_select;
        end
        else if (hit_flags)
        begin
            next_rdata[7:0] = ep_flags[endpoint_select];
        end
        else if (hit_enables)
        begin
            next_rdata[7:0] = ep_enables[endpoint_select];
        end
        else if (hit_cnt_hi)
        begin
            next_rdata[2:0] = ep_count[endpoint_select][CW-1:usb_ep_pkg::HIGH_COUNT_LSB];
        end
        else if (hit_cnt_lo)
        begin
            next_rdata[7:0] = ep_count[endpoint_select][usb_ep_pkg::HIGH_COUNT_LSB-1:0];
        end
        else if (hit_summary)
        begin
            next_rdata[N-1:0] = endpoint_irq_summary;
        end
        else if (hit_iso)
        begin
            next_rdata[1:0] = ep_iso[endpoint_select];
        end
        else if (hit_cfg)
        begin
            next_rdata[2:0] = ep_cfg[endpoint_select];
        end
        else if (hit_status)
        begin
            next_rdata[usb_ep_pkg::IRQ_W-1:0] = irq_status;
        end
        else if (hit_mask)
        begin
            next_rdata[usb_ep_pkg::IRQ_W-1:0] = irq_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            rd_wait <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata <= next_rdata;
            rd_wait <= 1'b0;
        end
        else if (data_read && !rd_wait)
        begin
            prdata <= {24'h00_0000, mem_bus.a_rdata};
            rd_wait <= 1'b1;
        end
        else if (done)
        begin
            rd_wait <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            endpoint_select <= 3'h0;
            irq_mask <= '0;
        end
        else if (wr_done)
        begin
            if (hit_select && !bad_select)
            begin
                endpoint_select <= wbyte[2:0];
            end
            else if (hit_mask)
            begin
                irq_mask <= wbyte[usb_ep_pkg::IRQ_W-1:0];
            end
        end
    end

    wire [usb_ep_pkg::IRQ_W-1:0] irq_set = {bad_select, cpu_bad, usb_bus_reset};
    wire [usb_ep_pkg::IRQ_W-1:0] irq_clr = (wr_done && hit_status)
        ? wbyte[usb_ep_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= '0;
            usb_tx_valid <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            usb_tx_valid <= usb_pop;
        end
    end

    property p_data_read_wait;
        @(posedge pclk) disable iff (!presetn)
        setup_ph && !pwrite && hit_data ##1 access_ph |-> !pready ##1 pready;
    endproperty
    a_data_read_wait: assert property (p_data_read_wait) else $error("data read timing");

    property p_select_guard;
        @(posedge pclk) disable iff (!presetn)
        bad_select |=> endpoint_select == $past(endpoint_select);
    endproperty
    a_select_guard: assert property (p_select_guard) else $error("forbidden select taken");

    property p_irq_line;
        @(posedge pclk) disable iff (!presetn)
        endpoint_irq == (endpoint_irq_summary != '0);
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("endpoint irq mismatch");

    property p_count_high_zero;
        @(posedge pclk) disable iff (!presetn)
        done && !pwrite && hit_cnt_hi |-> prdata[7:3] == 5'h00;
    endproperty
    a_count_high_zero: assert property (p_count_high_zero) else $error("count high bits");
endmodule

// >>> hw/usb_ep_pkg.sv
// constants for the endpoint status and fifo access block
// Contract
// - nak-in flag bit 6 set when an IN request gets NAK; software only clears.
// - bit 5 high when IN bank not full or OUT bank not empty; never on stall/error.
// - nak-out flag bit 4 set when OUT or PING gets NAK; writing one does nothing.
// - setup flag bit 3 set on new valid SETUP, interrupts if enabled; zero on IN.
// - out-data flag bit 2 set on new received packet; software clears, one ignored.
// - on IN endpoints writing one to bit 2 discards last bank; hardware clears it.
// - stalled flag bit 1 set on STALL sent or iso OUT CRC error; software clears.
// - tx-ready flag bit 0 set when IN bank free, interrupts if enabled; zero on OUT.
// - enable bit 7 lets iso overflow or underflow raise the endpoint interrupt.
// - enable bits gate each flag's interrupt; enable bit 5 reserved, reads zero.
// - 8-bit data port writes or reads one fifo byte of selected endpoint per access.
// - 11-bit byte count: high register bits 2-0, bits 7-3 zero; low register 8 bits.
// - IN count rises on cpu write, falls per byte sent; OUT the opposite way.
// - summary bits 6-0 follow enabled endpoint interrupts; bit 7 reads zero.
// - bank control bit set with out/setup or tx-ready; software clear releases bank.
package usb_ep_pkg;
    localparam int EP_COUNT = 7;
    localparam int SEL_W = 3;
    localparam logic [2:0] FORBIDDEN_SEL = 3'h7;
    localparam int COUNT_W = 11;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int APB_AW = 12;
    localparam logic [11:0] OFS_SELECT = 12'h000;
    localparam logic [11:0] OFS_FLAGS = 12'h004;
    localparam logic [11:0] OFS_ENABLES = 12'h008;
    localparam logic [11:0] OFS_DATA = 12'h00C;
    localparam logic [11:0] OFS_COUNT_HIGH = 12'h010;
    localparam logic [11:0] OFS_COUNT_LOW = 12'h014;
    localparam logic [11:0] OFS_SUMMARY = 12'h018;
    localparam logic [11:0] OFS_ISO_FLAGS = 12'h01C;
    localparam logic [11:0] OFS_CONFIG = 12'h020;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h024;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
    localparam int BIT_TX_READY = 0;
    localparam int BIT_STALL = 1;
    localparam int BIT_OUT_DATA = 2;
    localparam int BIT_SETUP = 3;
    localparam int BIT_NAK_OUT = 4;
    localparam int BIT_RW_ALLOWED = 5;
    localparam int BIT_NAK_IN = 6;
    localparam int BIT_BANK_CTRL = 7;
    localparam int BIT_FLOW_ERR_EN = 7;
    localparam logic [7:0] STORED_MASK = 8'hDF;
    localparam logic [7:0] ENABLE_MASK = 8'hDF;
    localparam logic [7:0] FLAG_IRQ_MASK = 8'h5F;
    localparam int CFG_DIR_IN = 0;
    localparam int CFG_ISO = 1;
    localparam int CFG_STALL_REQ = 2;
    localparam int ISO_OVER = 0;
    localparam int ISO_UNDER = 1;
    localparam int IRQ_W = 3;
    localparam int IRQ_BUS_RESET = 0;
    localparam int IRQ_ACCESS_ERR = 1;
    localparam int IRQ_BAD_SELECT = 2;
    localparam int HIGH_COUNT_LSB = 8;
endpackage

// >>> hw/fifo_mem_if.sv
// two-port connection between the controller and the fifo memory
`timescale 1ns/1ps
interface fifo_mem_if #(
    parameter int AW = 9
);
    logic a_we;
    logic [AW-1:0] a_addr;
    logic [7:0] a_wdata;
    logic [7:0] a_rdata;
    logic b_we;
    logic [AW-1:0] b_addr;
    logic [7:0] b_wdata;
    logic [7:0] b_rdata;
    modport ctrl (output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, input a_rdata, b_rdata);
    modport mem (input a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, output a_rdata, b_rdata);
endinterface

// >>> hw/ep_fifo_mem.sv
// dual-port byte memory holding every endpoint fifo
`timescale 1ns/1ps
module ep_fifo_mem #(
    parameter int AW = 9
)(
    input wire logic clk,
    fifo_mem_if.mem port
);
    logic [7:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (port.a_we)
        begin
            cells[port.a_addr] <= port.a_wdata;
        end
        if (port.b_we)
        begin
            cells[port.b_addr] <= port.b_wdata;
        end
        port.a_rdata <= cells[port.a_addr];
        port.b_rdata <= cells[port.b_addr];
    end
endmodule

// >>> hw/ep_state_unit.sv
// per-endpoint flags, enables, bank state and byte count
`timescale 1ns/1ps
module ep_state_unit #(
    parameter int DEPTH = usb_ep_pkg::FIFO_DEPTH,
    parameter int PTR_W = usb_ep_pkg::PTR_W,
    parameter int COUNT_W = usb_ep_pkg::COUNT_W
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic flags_we,
    input wire logic enables_we,
    input wire logic iso_we,
    input wire logic cfg_we,
    input wire logic [7:0] wdata,
    input wire logic ev_nak_in,
    input wire logic ev_nak_out,
    input wire logic ev_stall,
    input wire logic ev_crc,
    input wire logic ev_setup,
    input wire logic ev_out_done,
    input wire logic ev_in_done,
    input wire logic ev_overflow,
    input wire logic ev_underflow,
    input wire logic push,
    input wire logic pop,
    output logic [7:0] flags_rd,
    output logic [7:0] enables,
    output logic [1:0] iso_flags,
    output logic [2:0] cfg,
    output logic [COUNT_W-1:0] count,
    output logic [PTR_W-1:0] wr_ptr,
    output logic [PTR_W-1:0] rd_ptr,
    output logic bank_busy,
    output logic full,
    output logic empty,
    output logic irq_bit
);
    logic [7:0] flags;
    logic kill_pend;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    wire dir_in = cfg[usb_ep_pkg::CFG_DIR_IN];
    wire stall_req = cfg[usb_ep_pkg::CFG_STALL_REQ];
    wire kill_req = flags_we & dir_in & wdata[usb_ep_pkg::BIT_OUT_DATA];
    wire release_req = flags_we & ~wdata[usb_ep_pkg::BIT_BANK_CTRL]
        & flags[usb_ep_pkg::BIT_BANK_CTRL];
    wire cfg_to_in = cfg_we & wdata[usb_ep_pkg::CFG_DIR_IN] & ~dir_in;
    wire set_txin = (dir_in & (ev_in_done | kill_pend)) | cfg_to_in;
    wire set_setup = ~dir_in & ev_setup;
    wire set_out = ~dir_in & ev_out_done;
    wire set_stall = ev_stall | (ev_crc & cfg[usb_ep_pkg::CFG_ISO] & ~dir_in);
    wire flush = kill_pend | (~dir_in & release_req) | (dir_in & ev_in_done) | clr;
    wire next_busy = dir_in ? ((bank_busy | release_req) & ~ev_in_done & ~kill_pend)
        : ((bank_busy & ~release_req) | set_setup | set_out);
    wire rw_allowed = ~stall_req & ~(|iso_flags) & (dir_in ? (~bank_busy & ~full)
        : (bank_busy & ~empty));
    wire [7:0] next_flags = ((flags & ~clr_mask) | set_mask) & usb_ep_pkg::STORED_MASK;

    assign full = count >= COUNT_W'(DEPTH);
    assign empty = count == '0;
    assign clr_mask = flags_we ? ~wdata : 8'h00;

    always_comb
    begin
        set_mask = 8'h00;
        set_mask[usb_ep_pkg::BIT_NAK_IN] = ev_nak_in;
        set_mask[usb_ep_pkg::BIT_NAK_OUT] = ev_nak_out;
        set_mask[usb_ep_pkg::BIT_SETUP] = set_setup;
        set_mask[usb_ep_pkg::BIT_OUT_DATA] = set_out;
        set_mask[usb_ep_pkg::BIT_STALL] = set_stall;
        set_mask[usb_ep_pkg::BIT_TX_READY] = set_txin;
        set_mask[usb_ep_pkg::BIT_BANK_CTRL] = set_txin | set_setup | set_out;
    end

    always_comb
    begin
        flags_rd = flags;
        flags_rd[usb_ep_pkg::BIT_RW_ALLOWED] = rw_allowed;
        flags_rd[usb_ep_pkg::BIT_SETUP] = ~dir_in & flags[usb_ep_pkg::BIT_SETUP];
        flags_rd[usb_ep_pkg::BIT_TX_READY] = dir_in & flags[usb_ep_pkg::BIT_TX_READY];
        flags_rd[usb_ep_pkg::BIT_OUT_DATA] = dir_in ? kill_pend
            : flags[usb_ep_pkg::BIT_OUT_DATA];
    end

    assign irq_bit = (|(flags_rd & enables & usb_ep_pkg::FLAG_IRQ_MASK))
        | (enables[usb_ep_pkg::BIT_FLOW_ERR_EN] & (|iso_flags));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags <= 8'h00;
            kill_pend <= 1'b0;
            bank_busy <= 1'b0;
        end
        else
        begin
            flags <= clr ? 8'h00 : next_flags;
            kill_pend <= kill_req & ~clr;
            bank_busy <= next_busy & ~clr;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            enables <= 8'h00;
            iso_flags <= 2'h0;
            cfg <= 3'h0;
        end
        else if (clr)
        begin
            enables <= 8'h00;
            iso_flags <= 2'h0;
            cfg <= 3'h0;
        end
        else
        begin
            if (enables_we)
            begin
                enables <= wdata & usb_ep_pkg::ENABLE_MASK;
            end
            iso_flags <= (iso_flags & ~(iso_we ? ~wdata[1:0] : 2'h0))
                | {ev_underflow, ev_overflow};
            if (cfg_we)
            begin
                cfg <= wdata[2:0];
            end
            else if (ev_setup)
            begin
                cfg[usb_ep_pkg::CFG_STALL_REQ] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (flush)
        begin
            count <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            count <= count + COUNT_W'(push) - COUNT_W'(pop);
            wr_ptr <= wr_ptr + PTR_W'(push);
            rd_ptr <= rd_ptr + PTR_W'(pop);
        end
    end

    property p_nak_in_set;
        @(posedge clk) disable iff (!rstn)
        ev_nak_in && !clr |=> flags_rd[usb_ep_pkg::BIT_NAK_IN];
    endproperty
    a_nak_in_set: assert property (p_nak_in_set) else $error("nak-in flag not set");

    property p_one_no_set;
        @(posedge clk) disable iff (!rstn)
        flags_we && !flags[usb_ep_pkg::BIT_NAK_OUT] && !ev_nak_out
            |=> !flags_rd[usb_ep_pkg::BIT_NAK_OUT];
    endproperty
    a_one_no_set: assert property (p_one_no_set) else $error("software set nak-out");

    property p_kill_self_clear;
        @(posedge clk) disable iff (!rstn)
        kill_pend |=> !kill_pend && (!dir_in || flags_rd[usb_ep_pkg::BIT_TX_READY]);
    endproperty
    a_kill_self_clear: assert property (p_kill_self_clear) else $error("kill stuck");

    property p_count_step;
        @(posedge clk) disable iff (!rstn)
        push && !pop && !flush |=> count == $past(count) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not rise");

    property p_rw_stall;
        @(posedge clk) disable iff (!rstn)
        stall_req |-> !flags_rd[usb_ep_pkg::BIT_RW_ALLOWED];
    endproperty
    a_rw_stall: assert property (p_rw_stall) else $error("rw allowed under stall");
endmodule

// >>> test/usb_host_model.sv
// host side driver of the usb event, byte and request inputs
`timescale 1ns/1ps
module usb_host_model(
    input wire logic pclk,
    output logic [2:0] ep = 3'h0,
    output logic [10:0] ev = 11'h000,
    output logic [7:0] rx_b = 8'h00
);
    // one-cycle pulse of event line k for endpoint e
    task pulse(input logic [2:0] e, input int k);
        @(posedge pclk);
        {ep, ev} <= {e, 11'h001 << k};
        @(posedge pclk);
        ev <= 11'h000;
    endtask
    // byte line inverted once released
    task send(input logic [2:0] e, input logic [7:0] b);
        rx_b <= b;
        pulse(e, 10);
        rx_b <= ~b;
    endtask
endmodule

// >>> test/usb_endpoint_status_fifo_access_tb_top.sv
// self-checking bench for the endpoint status and fifo access block
`timescale 1ns/1ps
module usb_endpoint_status_fifo_access_tb_top;
    localparam logic [11:0] fl = usb_ep_pkg::OFS_FLAGS, cl = usb_ep_pkg::OFS_COUNT_LOW;
    localparam logic [11:0] dat = usb_ep_pkg::OFS_DATA;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, usb_tx_valid, endpoint_irq, irq;
    logic [2:0] usb_ep;
    logic [10:0] ev;
    logic [7:0] rx_b, usb_tx_byte;
    logic [6:0] in_bank_ready, obf, stq;
    logic [7:0] fb [3] = '{8'h40, 8'h10, 8'h02};
    int fail_count = 0, compares = 0;
    always #10 pclk = ~pclk;
    usb_host_model host(.pclk, .ep(usb_ep), .ev, .rx_b);
    usb_ep_access uut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .usb_bus_reset(1'b0), .usb_ep, .usb_nak_in(ev[0]),
        .usb_nak_out(ev[1]), .usb_stall_sent(ev[2]), .usb_iso_crc_err(ev[3]),
        .usb_setup_done(ev[4]), .usb_out_done(ev[5]), .usb_in_done(ev[6]),
        .usb_overflow(ev[7]), .usb_underflow(ev[8]), .usb_tx_req(ev[9]),
        .usb_rx_valid(ev[10]), .usb_rx_byte(rx_b), .usb_tx_byte, .usb_tx_valid,
        .in_bank_ready, .out_bank_free(obf), .stall_request(stq), .endpoint_irq, .irq);
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        fail_count += int'(s !== e);
        if (s !== e)
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    endtask
    // apb transfer; a read compares its data with d
    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk({7'h00, pslverr}, {7'h00, a > usb_ep_pkg::OFS_IRQ_MASK});
        if (!w)
            chk(prdata[7:0], d);
        {psel, penable} <= 2'b00;
    endtask
    task wrap_up(input int extra);
        fail_count += extra;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial #1ms wrap_up(1);
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b1, usb_ep_pkg::OFS_ENABLES, 8'hFF);
        xfer(1'b0, usb_ep_pkg::OFS_ENABLES, 8'hDF);
        for (int i = 0; i < 3; i++)
        begin
            host.pulse(3'h0, i);
            xfer(1'b0, fl, fb[i]);
            xfer(1'b0, usb_ep_pkg::OFS_SUMMARY, 8'h01);
            chk({7'h00, endpoint_irq}, 8'h01);
            xfer(1'b1, fl, 8'hFF);
            xfer(1'b0, fl, fb[i]);
            xfer(1'b1, fl, ~fb[i]);
        end
        xfer(1'b0, usb_ep_pkg::OFS_SUMMARY, 8'h00);
        $display("test flags done");
        host.send(3'h0, 8'hA1);
        xfer(1'b0, cl, 8'h01);
        xfer(1'b0, usb_ep_pkg::OFS_COUNT_HIGH, 8'h00);
        host.pulse(3'h0, 5);
        xfer(1'b0, fl, 8'hA4);
        xfer(1'b0, dat, 8'hA1);
        xfer(1'b0, cl, 8'h00);
        xfer(1'b1, fl, 8'h7B);
        host.pulse(3'h0, 4);
        xfer(1'b0, fl, 8'h88);
        xfer(1'b1, fl, 8'h77);
        $display("test out done");
        xfer(1'b1, usb_ep_pkg::OFS_SELECT, 8'h02);
        xfer(1'b1, usb_ep_pkg::OFS_CONFIG, 8'h01);
        xfer(1'b0, fl, 8'hA1);
        xfer(1'b1, dat, 8'h5A);
        xfer(1'b1, dat, 8'h6B);
        xfer(1'b0, cl, 8'h02);
        xfer(1'b1, fl, 8'hFF);
        xfer(1'b0, cl, 8'h00);
        xfer(1'b1, dat, 8'h3C);
        xfer(1'b1, fl, 8'h7A);
        xfer(1'b0, cl, 8'h01);
        chk({1'b0, in_bank_ready}, 8'h04);
        host.pulse(3'h2, 9);
        @(negedge pclk);
        chk(usb_tx_byte, 8'h3C);
        chk({7'h00, usb_tx_valid}, 8'h01);
        xfer(1'b0, cl, 8'h00);
        xfer(1'b1, usb_ep_pkg::OFS_ENABLES, 8'h80);
        host.pulse(3'h2, 7);
        xfer(1'b0, usb_ep_pkg::OFS_SUMMARY, 8'h04);
        xfer(1'b1, usb_ep_pkg::OFS_ISO_FLAGS, 8'h00);
        xfer(1'b0, usb_ep_pkg::OFS_SUMMARY, 8'h00);
        $display("test in done");
        xfer(1'b1, usb_ep_pkg::OFS_SELECT, 8'h07); // deliberately forbidden
        xfer(1'b0, usb_ep_pkg::OFS_SELECT, 8'h02);
        xfer(1'b1, usb_ep_pkg::OFS_IRQ_MASK, 8'h04);
        xfer(1'b0, 12'h0FC, 8'h00);
        chk({7'h00, irq}, 8'h01);
        xfer(1'b1, usb_ep_pkg::OFS_IRQ_STATUS, 8'h04);
        xfer(1'b0, usb_ep_pkg::OFS_IRQ_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test irq done");
        xfer(1'b1, usb_ep_pkg::OFS_CONFIG, 8'h05);
        xfer(1'b0, fl, 8'h00);
        chk({1'b0, stq}, 8'h04);
        host.pulse(3'h2, 4);
        @(negedge pclk);
        chk({1'b0, stq}, 8'h00);
        chk({1'b0, obf}, 8'h7B);
        $display("test stall done");
        wrap_up(0);
    end
endmodule
